// [acl_rule_filter_engine.sv]
// access-control rule table, matcher, action arbiter and packet timer
// Operation
// - rule kind selects off, L2, L3, L4
// - L2 select 00 uses action bits as count
// - forward msb picks microsecond or millisecond unit
// - down mode reloads, interrupt on silent expiry
// - up mode counts hits, interrupt, then clears
// - L2 selects type, address or both
// - L3 masked address or source equals destination
// - L4 protocol, tcp port, udp port, sequence
// - side bit picks destination or source
// - polarity bit: equal or unequal is hit
// - entry holds mac, type, address, mask
// - port range compare off/either/inside/outside
// - optional tcp flag test, protocol code
// - priority keep, raise, lower or replace
// - remark vlan priority of tagged packets
// - forward map keep, or, and, replace
// - forward vector has one bit per port
// - group hits when all member entries hit
// - group applies its lead entry's action
// - lowest lead index wins among groups
// - per-port enable, else packets bypass
`timescale 1ns/100ps
`default_nettype none
module acl_rule_filter_engine
  import acl_pkg::*;
#(
  parameter int N_ENTRIES = acl_pkg::ENTRIES,
  parameter int N_PORTS   = acl_pkg::PORTS
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic [4:0]  port_acl_en,
  input  wire logic        pkt_valid,
  input  wire logic [2:0]  pkt_port,
  input  wire logic [47:0] pkt_dmac,
  input  wire logic [47:0] pkt_smac,
  input  wire logic [15:0] pkt_etype,
  input  wire logic [31:0] pkt_dip,
  input  wire logic [31:0] pkt_sip,
  input  wire logic [7:0]  pkt_code,
  input  wire logic        pkt_is_tcp,
  input  wire logic        pkt_is_udp,
  input  wire logic [15:0] pkt_dport,
  input  wire logic [15:0] pkt_sport,
  input  wire logic [31:0] pkt_seq,
  input  wire logic [5:0]  pkt_flags,
  input  wire logic        pkt_tagged,
  input  wire logic [2:0]  pkt_vlan_prio,
  input  wire logic [2:0]  qos_prio,
  input  wire logic [4:0]  lookup_map,
  output logic             res_valid,
  output logic             res_hit,
  output logic      [2:0]  res_prio,
  output logic             res_remark,
  output logic      [2:0]  res_vlan_prio,
  output logic      [4:0]  res_map,
  output logic             count_irq
);
  import acl_pkg::*;

  if (N_ENTRIES != 16 || N_PORTS != 5) begin : g_chk
    $error("only 16 entries and 5 ports are supported");
  end

  logic [EW-1:0] table_reg [ENTRIES];
  logic [EW-1:0] table_next [ENTRIES];
  logic [7:0] ctl_lo_reg, ctl_lo_next, ctl_hi_reg, ctl_hi_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [3:0] sel_ent;
  logic       byte_ok;

  assign sel_ent = ctl_hi_reg[3:0];
  assign byte_ok = ctl_lo_reg < 8'(ENTRY_BYTES);

  // host side: entry in high control byte, byte lane in low
  always_comb begin : regs
    for (int i = 0; i < ENTRIES; i++) table_next[i] = table_reg[i];
    ctl_lo_next = ctl_lo_reg;
    ctl_hi_next = ctl_hi_reg;
    rdata_next  = rdata_reg;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_CTL_LO: ctl_lo_next = reg_wdata;
        ADDR_CTL_HI: ctl_hi_next = reg_wdata;
        ADDR_BYTE: begin
          if (byte_ok) begin
            table_next[sel_ent][ctl_lo_reg[4:0]*8 +: 8] = reg_wdata;
          end
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CTL_LO: rdata_next = ctl_lo_reg;
        ADDR_CTL_HI: rdata_next = ctl_hi_reg;
        ADDR_BYTE: rdata_next = byte_ok ?
          table_reg[sel_ent][ctl_lo_reg[4:0]*8 +: 8] : 8'h00;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < ENTRIES; i++) table_reg[i] <= '0;
      ctl_lo_reg <= 8'h00;
      ctl_hi_reg <= 8'h00;
      rdata_reg  <= 8'h00;
    end else begin
      for (int i = 0; i < ENTRIES; i++) table_reg[i] <= table_next[i];
      ctl_lo_reg <= ctl_lo_next;
      ctl_hi_reg <= ctl_hi_next;
      rdata_reg  <= rdata_next;
    end
  end
  assign reg_rdata = rdata_reg;

  // per-entry match, all entries in parallel
  logic [15:0] hit, kind_off, is_cnt;
  always_comb begin : match
    logic [EW-1:0] e;
    logic [15:0] pt, lo, hi;
    logic [31:0] ipa, msk;
    logic eq, vld, rok, pin;
    e = '0; pt = '0; lo = '0; hi = '0; ipa = '0; msk = '0;
    eq = 1'b0; vld = 1'b0; rok = 1'b0; pin = 1'b0;
    for (int i = 0; i < ENTRIES; i++) begin
      e   = table_reg[i];
      pt  = e[F_SIDE] ? pkt_sport : pkt_dport;
      ipa = e[F_SIDE] ? pkt_sip : pkt_dip;
      msk = e[F_MASK +: 32];
      lo  = e[F_MIN +: 16];
      hi  = e[F_MAX +: 16];
      pin = (pt >= lo) && (pt <= hi);
      case (e[F_RNG +: 2])
        2'h0: rok = 1'b1;
        2'h1: rok = (pt == lo) || (pt == hi);
        2'h2: rok = pin;
        default: rok = !pin;
      endcase
      vld = 1'b1;
      eq  = 1'b0;
      case (e[F_KIND +: 2])
        KIND_L2: begin
          case (e[F_TSEL +: 2])
            2'h1: eq = pkt_etype == e[F_ETYPE +: 16];
            2'h2: eq = (e[F_SIDE] ? pkt_smac : pkt_dmac) == e[F_MAC +: 48];
            default: eq = pkt_etype == e[F_ETYPE +: 16] &&
              (e[F_SIDE] ? pkt_smac : pkt_dmac) == e[F_MAC +: 48];
          endcase
        end
        KIND_L3: begin
          case (e[F_TSEL +: 2])
            2'h1: eq = (ipa & msk) == (e[F_IP +: 32] & msk);
            2'h2: eq = pkt_sip == pkt_dip;
            default: vld = 1'b0;
          endcase
        end
        KIND_L4: begin
          case (e[F_TSEL +: 2])
            2'h0: eq = pkt_code == e[F_CODE +: 8];
            2'h1: eq = pkt_is_tcp && rok;
            2'h2: eq = pkt_is_udp && rok;
            default: eq = pkt_is_tcp && pkt_seq == {hi, lo};
          endcase
          if (e[F_TCPON]) eq = eq && pkt_flags == e[F_FLAG +: 6];
        end
        default: vld = 1'b0;
      endcase
      hit[i] = vld && (e[F_POL] ? eq : !eq);
      kind_off[i] = e[F_KIND +: 2] == KIND_OFF;
      is_cnt[i] = e[F_KIND +: 2] == KIND_L2 && e[F_TSEL +: 2] == 2'h0;
    end
  end

  // group evaluation and arbitration on lead index
  logic [15:0] grp_hit;
  logic [3:0]  best;
  logic        win;
  always_comb begin : arb
    logic [15:0] m;
    m = '0;
    best = 4'hF;
    win = 1'b0;
    for (int g = 0; g < ENTRIES; g++) begin
      m = table_reg[g][F_GROUP +: 16];
      // counter entries carry a count, not an action
      grp_hit[g] = !kind_off[g] && !is_cnt[g] && m != 16'h0000 &&
                   (m & ~hit) == 16'h0000;
      if (grp_hit[g] && (!win || table_reg[g][F_LEAD +: 4] < best)) begin
        best = table_reg[g][F_LEAD +: 4];
        win  = 1'b1;
      end
    end
  end

  logic [EW-1:0] act;
  logic port_on;
  assign act = table_reg[best];
  assign port_on = pkt_port < 3'(PORTS) && port_acl_en[pkt_port];

  logic       rv_reg, rv_next, rh_reg, rh_next, rm_reg, rm_next;
  logic [2:0] rp_reg, rp_next, rvp_reg, rvp_next;
  logic [4:0] map_reg, map_next;
  always_comb begin : action
    logic [2:0] p;
    logic [4:0] f;
    p = act[F_PRIO +: 3];
    f = act[F_FWD +: 5];
    rv_next  = pkt_valid;
    rh_next  = 1'b0;
    rp_next  = qos_prio;
    rm_next  = 1'b0;
    rvp_next = pkt_vlan_prio;
    map_next = lookup_map;
    if (pkt_valid && port_on && win) begin
      rh_next = 1'b1;
      case (act[F_PSEL +: 2])
        2'h1: rp_next = p > qos_prio ? p : qos_prio;
        2'h2: rp_next = p < qos_prio ? p : qos_prio;
        2'h3: rp_next = p;
        default: rp_next = qos_prio;
      endcase
      if (act[F_RMK] && pkt_tagged) begin
        rm_next  = 1'b1;
        rvp_next = act[F_RVAL +: 3];
      end
      case (act[F_MAPSEL +: 2])
        2'h1: map_next = lookup_map | f;
        2'h2: map_next = lookup_map & f;
        2'h3: map_next = f;
        default: map_next = lookup_map;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rv_reg <= 1'b0; rh_reg <= 1'b0; rm_reg <= 1'b0;
      rp_reg <= 3'h0; rvp_reg <= 3'h0; map_reg <= 5'h00;
    end else begin
      rv_reg <= rv_next; rh_reg <= rh_next; rm_reg <= rm_next;
      rp_reg <= rp_next; rvp_reg <= rvp_next; map_reg <= map_next;
    end
  end
  assign res_valid = rv_reg;
  assign res_hit = rh_reg;
  assign res_prio = rp_reg;
  assign res_remark = rm_reg;
  assign res_vlan_prio = rvp_reg;
  assign res_map = map_reg;

  // packet timer: serves the lowest counter entry only
  logic [3:0] csel;
  logic       cfound;
  always_comb begin : pick
    csel = 4'h0;
    cfound = 1'b0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (is_cnt[i]) begin
        csel = 4'(i);
        cfound = 1'b1;
      end
    end
  end

  logic [EW-1:0] ce;
  logic [CNT_W-1:0] cval;
  logic cmatch, up_mode, tick;
  assign ce = table_reg[csel];
  assign cval = ce[F_COUNT +: CNT_W];
  assign up_mode = ce[F_FWD + 3];
  assign cmatch = pkt_valid && port_on && cfound && hit[csel];

  logic [5:0] pre_reg, pre_next;
  logic [9:0] ms_reg, ms_next;
  logic us_tick, ms_tick;
  assign us_tick = pre_reg == 6'(US_CYC - 1);
  assign ms_tick = us_tick && ms_reg == 10'(MS_US - 1);
  assign tick = ce[F_FWD + 4] ? ms_tick : us_tick;

  cnt_state_e st_reg, st_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic irq_reg, irq_next;
  always_comb begin : timer
    pre_next = us_tick ? 6'h00 : pre_reg + 6'h01;
    ms_next  = ms_tick ? 10'h000 : (us_tick ? ms_reg + 10'h001 : ms_reg);
    st_next  = st_reg;
    cnt_next = cnt_reg;
    irq_next = 1'b0;
    if (up_mode) begin
      st_next = CNT_IDLE;
      if (cmatch) begin
        if ({1'b0, cnt_reg} + 12'h001 >= {1'b0, cval}) begin
          irq_next = 1'b1;
          cnt_next = '0;
        end else begin
          cnt_next = cnt_reg + 11'h001;
        end
      end
    end else begin
      case (st_reg)
        CNT_IDLE: begin
          if (cmatch) begin
            cnt_next = cval;
            st_next  = CNT_RUN;
          end
        end
        CNT_RUN: begin
          // a fresh hit restarts the window before any expiry
          if (cmatch) begin
            cnt_next = cval;
          end else if (tick) begin
            if (cnt_reg <= 11'h001) begin
              irq_next = 1'b1;
              cnt_next = '0;
              st_next  = CNT_IDLE;
            end else begin
              cnt_next = cnt_reg - 11'h001;
            end
          end
        end
        default: st_next = CNT_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pre_reg <= 6'h00;
      ms_reg  <= 10'h000;
      st_reg  <= CNT_IDLE;
      cnt_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      ms_reg  <= ms_next;
      st_reg  <= st_next;
      cnt_reg <= cnt_next;
      irq_reg <= irq_next;
    end
  end
  assign count_irq = irq_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  property p_off_no_hit;
    (hit & kind_off) == 16'h0000;
  endproperty
  a_off_no_hit: assert property (p_off_no_hit)
    else $error("disabled entry reported a hit");

  property p_bypass;
    pkt_valid && !port_on |=> res_valid && !res_hit &&
      res_map == $past(lookup_map) && res_prio == $past(qos_prio);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("disabled port was filtered");

  property p_miss;
    pkt_valid && !win |=> !res_hit && !res_remark &&
      res_vlan_prio == $past(pkt_vlan_prio);
  endproperty
  a_miss: assert property (p_miss)
    else $error("missed packet was altered");

  property p_replace;
    pkt_valid && port_on && win && act[F_PSEL +: 2] == 2'h3
      |=> res_prio == $past(act[F_PRIO +: 3]);
  endproperty
  a_replace: assert property (p_replace)
    else $error("priority not replaced");

  property p_and_map;
    pkt_valid && port_on && win && act[F_MAPSEL +: 2] == 2'h2
      |=> res_map == ($past(lookup_map) & $past(act[F_FWD +: 5]));
  endproperty
  a_and_map: assert property (p_and_map)
    else $error("forward map not and-ed");

  property p_remark;
    pkt_valid && port_on && win && act[F_RMK] && pkt_tagged
      |=> res_remark && res_vlan_prio == $past(act[F_RVAL +: 3]);
  endproperty
  a_remark: assert property (p_remark)
    else $error("tag priority not remarked");

  property p_lead;
    (grp_hit != 16'h0000) == win;
  endproperty
  a_lead: assert property (p_lead)
    else $error("winner without a matching group");

  property p_up_wrap;
    up_mode && cmatch && {1'b0, cnt_reg} + 12'h001 >= {1'b0, cval}
      |=> count_irq && cnt_reg == '0;
  endproperty
  a_up_wrap: assert property (p_up_wrap)
    else $error("up count did not wrap");

  property p_expire;
    !up_mode && st_reg == CNT_RUN && tick && !cmatch &&
      cnt_reg == 11'h001 |=> count_irq ##1 !count_irq;
  endproperty
  a_expire: assert property (p_expire)
    else $error("expiry interrupt missing");

  property p_byte_rw;
    (reg_wr && reg_addr == ADDR_BYTE && byte_ok) ##1
      (reg_rd && !reg_wr && reg_addr == ADDR_BYTE && $stable(ctl_lo_reg)
       && $stable(ctl_hi_reg)) |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_byte_rw: assert property (p_byte_rw)
    else $error("table byte read back wrong");

  c_hit: cover property (pkt_valid && port_on && win);
  c_irq: cover property (count_irq);
  c_remark: cover property (res_remark);
endmodule : acl_rule_filter_engine
`default_nettype wire

// [acl_pkg.sv]
// constants for the ingress access-control rule engine
package acl_pkg;
  localparam logic [7:0] ADDR_CTL_LO = 8'h6E;
  localparam logic [7:0] ADDR_CTL_HI = 8'h6F;
  localparam logic [7:0] ADDR_BYTE   = 8'hA0;
  localparam int ENTRIES  = 16;
  localparam int PORTS    = 5;
  localparam int ENTRY_BYTES = 28;
  localparam int EW       = ENTRY_BYTES * 8;
  // entry field positions (lsb) inside one table entry
  localparam int F_KIND   = 0;
  localparam int F_TSEL   = 2;
  localparam int F_SIDE   = 4;
  localparam int F_POL    = 5;
  localparam int F_MAC    = 6;
  localparam int F_ETYPE  = 54;
  localparam int F_IP     = 70;
  localparam int F_MASK   = 102;
  localparam int F_MIN    = 134;
  localparam int F_MAX    = 150;
  localparam int F_RNG    = 166;
  localparam int F_CODE   = 168;
  localparam int F_TCPON  = 176;
  localparam int F_FLAG   = 177;
  localparam int F_MAPSEL = 183;
  localparam int F_RVAL   = 185;
  localparam int F_RMK    = 188;
  localparam int F_PRIO   = 189;
  localparam int F_PSEL   = 192;
  localparam int F_FWD    = 194;
  localparam int F_LEAD   = 199;
  localparam int F_GROUP  = 203;
  localparam int F_COUNT  = 183;
  localparam int CNT_W    = 11;
  localparam logic [1:0] KIND_OFF = 2'h0;
  localparam logic [1:0] KIND_L2  = 2'h1;
  localparam logic [1:0] KIND_L3  = 2'h2;
  localparam logic [1:0] KIND_L4  = 2'h3;
  // timing
  localparam int CLK_NS   = 20;
  localparam int US_NS    = 1000;
  localparam int MS_NS    = 1000000;
  localparam int US_CYC   = (US_NS + CLK_NS - 1) / CLK_NS;
  localparam int MS_US    = MS_NS / US_NS;
  typedef enum logic [1:0] {
    CNT_IDLE = 2'b01,
    CNT_RUN  = 2'b10
  } cnt_state_e;
endpackage : acl_pkg

// [lookup_partner.sv]
// far-side model: lookup and qos stage presenting per-packet metadata
`timescale 1ns/100ps
`default_nettype none
module lookup_partner (
  input  wire logic       clock,
  input  wire logic       send,
  output logic            pkt_valid,
  output logic      [2:0] qos_prio,
  output logic      [4:0] lookup_map,
  output logic            pkt_tagged,
  output logic      [2:0] pkt_vlan_prio
);
  initial begin
    pkt_valid = 1'b0;
    qos_prio = 3'h0;
    lookup_map = 5'h00;
    pkt_tagged = 1'b0;
    pkt_vlan_prio = 3'h0;
  end
  // fields flip outside a packet so a stale value is never trusted
  always @(posedge clock) begin
    pkt_valid <= send;
    qos_prio <= send ? 3'($urandom) : ~qos_prio;
    lookup_map <= send ? 5'($urandom) : ~lookup_map;
    pkt_tagged <= send ? 1'($urandom) : ~pkt_tagged;
    pkt_vlan_prio <= send ? 3'($urandom) : ~pkt_vlan_prio;
  end
endmodule : lookup_partner
`default_nettype wire

// [tb_acl_rule_filter_engine.sv]
// self-checking bench for the access-control rule engine
`timescale 1ns/100ps
`default_nettype none
module tb_acl_rule_filter_engine;
  import acl_pkg::*;
  logic          clock, rstn, reg_wr, reg_rd, send, pkt_valid, pkt_tagged;
  logic          pkt_is_tcp, pkt_is_udp, res_valid, res_hit, res_remark;
  logic          count_irq, irq;
  logic [2:0]    pkt_port, pkt_vlan_prio, qos_prio, res_prio, res_vlan_prio;
  logic [4:0]    port_acl_en, lookup_map, res_map;
  logic [5:0]    pkt_flags;
  logic [7:0]    reg_addr, reg_wdata, reg_rdata, pkt_code, d;
  logic [15:0]   pkt_etype, pkt_dport, pkt_sport;
  logic [31:0]   pkt_dip, pkt_sip, pkt_seq;
  logic [47:0]   pkt_dmac, pkt_smac;
  logic [EW-1:0] tbl [ENTRIES];
  int            failures, checks_done, c;
  localparam int        UP_MODE [6] = '{1, 2, 1, 1, 3, 1};
  localparam logic [5:0] UP_IRQ     = 6'b100100;

  acl_rule_filter_engine u_dut (
    .clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .port_acl_en(port_acl_en), .pkt_valid(pkt_valid), .pkt_port(pkt_port),
    .pkt_dmac(pkt_dmac), .pkt_smac(pkt_smac), .pkt_etype(pkt_etype),
    .pkt_dip(pkt_dip), .pkt_sip(pkt_sip), .pkt_code(pkt_code),
    .pkt_is_tcp(pkt_is_tcp), .pkt_is_udp(pkt_is_udp),
    .pkt_dport(pkt_dport), .pkt_sport(pkt_sport), .pkt_seq(pkt_seq),
    .pkt_flags(pkt_flags), .pkt_tagged(pkt_tagged),
    .pkt_vlan_prio(pkt_vlan_prio), .qos_prio(qos_prio),
    .lookup_map(lookup_map), .res_valid(res_valid), .res_hit(res_hit),
    .res_prio(res_prio), .res_remark(res_remark),
    .res_vlan_prio(res_vlan_prio), .res_map(res_map), .count_irq(count_irq));
  lookup_partner u_src (
    .clock(clock), .send(send), .pkt_valid(pkt_valid),
    .qos_prio(qos_prio), .lookup_map(lookup_map), .pkt_tagged(pkt_tagged),
    .pkt_vlan_prio(pkt_vlan_prio));

  initial begin
    clock = 1'b0;
    forever #(CLK_NS / 2) clock = ~clock;
  end

  task automatic stop_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task automatic put(input int k);
    wr(ADDR_CTL_HI, 8'(k));
    for (int b = 0; b < ENTRY_BYTES; b++) begin
      wr(ADDR_CTL_LO, 8'(b));
      wr(ADDR_BYTE, tbl[k][8*b +: 8]);
    end
  endtask : put

  function automatic logic [EW-1:0] rand_entry(int k);
    logic [EW-1:0] e;
    logic [15:0]   mn;
    for (int i = 0; i < EW / 32; i++) e[32*i +: 32] = $urandom;
    e[1:0] = ($urandom % 8 == 0) ? KIND_OFF : 2'(1 + $urandom % 3);
    // counter entries stay out of the random tables
    if (e[1:0] == KIND_L2 && e[3:2] == 2'h0) e[3:2] = 2'h3;
    if (e[1:0] == KIND_L4 && e[3:2] != 2'h0) e[F_POL] = 1'b1;
    e[F_MAC +: 48] = 48'($urandom % 2);
    e[F_ETYPE +: 16] = 16'h0800 + 16'($urandom % 2);
    e[F_IP +: 32] = 32'($urandom % 4);
    mn = 16'($urandom % 4);
    e[F_MIN +: 16] = mn;
    e[F_MAX +: 16] = mn + 16'($urandom % 3);
    e[F_RNG +: 2] = 2'($urandom);
    e[F_CODE +: 8] = 8'h06 + 8'($urandom % 2);
    e[F_TCPON] = 1'($urandom);
    e[F_FLAG +: 6] = 6'($urandom % 2);
    e[F_GROUP +: 16] = 16'(1 << k) | 16'(1 << ($urandom % 16));
    return e;
  endfunction : rand_entry

  function automatic logic ent_hit(int j);
    logic [EW-1:0] e;
    logic [15:0]   p, mn, mx;
    logic          eq, inr, mq, tq;
    e = tbl[j];
    p = e[F_SIDE] ? pkt_sport : pkt_dport;
    mn = e[F_MIN +: 16];
    mx = e[F_MAX +: 16];
    inr = p >= mn && p <= mx;
    if (e[F_RNG +: 2] == 2'h0) inr = 1'b1;
    if (e[F_RNG +: 2] == 2'h1) inr = p == mn || p == mx;
    if (e[F_RNG +: 2] == 2'h3) inr = !inr;
    mq = (e[F_SIDE] ? pkt_smac : pkt_dmac) == e[F_MAC +: 48];
    tq = pkt_etype == e[F_ETYPE +: 16];
    case ({e[1:0], e[3:2]})
      4'h5: eq = tq;
      4'h6: eq = mq;
      4'h7: eq = mq && tq;
      4'h9: eq = (((e[F_SIDE] ? pkt_sip : pkt_dip) ^ e[F_IP +: 32])
                 & e[F_MASK +: 32]) == 32'h0;
      4'hA: eq = pkt_sip == pkt_dip;
      4'hC: eq = pkt_code == e[F_CODE +: 8];
      4'hD: eq = pkt_is_tcp && inr;
      4'hE: eq = pkt_is_udp && inr;
      4'hF: eq = pkt_is_tcp && pkt_seq == {mx, mn};
      default: return 1'b0;
    endcase
    if (e[1:0] == KIND_L4 && e[F_TCPON])
      eq = eq && pkt_flags == e[F_FLAG +: 6];
    return e[F_POL] ? eq : !eq;
  endfunction : ent_hit

  function automatic logic [13:0] expect_res();
    int            best;
    logic          ok, rm;
    logic [EW-1:0] a;
    logic [2:0]    pr, ep;
    logic [4:0]    mp, fv;
    best = 16;
    for (int k = 0; k < ENTRIES; k++) begin
      ok = 1'b1;
      for (int j = 0; j < ENTRIES; j++)
        if (tbl[k][F_GROUP + j] && !ent_hit(j)) ok = 1'b0;
      if (ok && tbl[k][F_LEAD +: 4] < best) best = tbl[k][F_LEAD +: 4];
    end
    if (pkt_port > 3'd4 || !port_acl_en[pkt_port] || best == 16)
      return {2'b10, qos_prio, 1'b0, pkt_vlan_prio, lookup_map};
    a = tbl[best];
    ep = a[F_PRIO +: 3];
    fv = a[F_FWD +: 5];
    case (a[F_PSEL +: 2])
      2'h0: pr = qos_prio;
      2'h1: pr = ep > qos_prio ? ep : qos_prio;
      2'h2: pr = ep < qos_prio ? ep : qos_prio;
      default: pr = ep;
    endcase
    case (a[F_MAPSEL +: 2])
      2'h0: mp = lookup_map;
      2'h1: mp = lookup_map | fv;
      2'h2: mp = lookup_map & fv;
      default: mp = fv;
    endcase
    rm = a[F_RMK] & pkt_tagged;
    return {2'b11, pr, rm, rm ? a[F_RVAL +: 3] : pkt_vlan_prio, mp};
  endfunction : expect_res

  // mode 0 random and checked, 1 timer match, 2 miss, 3 match on port 5
  task automatic send_pkt(input int m, output logic ir);
    logic [13:0] ex;
    logic        tcp;
    @(posedge clock);
    send <= 1'b1;
    @(posedge clock);
    send <= 1'b0;
    tcp = 1'($urandom);
    pkt_is_tcp <= tcp;
    pkt_is_udp <= !tcp;
    pkt_port <= (m == 0) ? 3'($urandom % 6) : (m == 3 ? 3'd5 : 3'd0);
    pkt_dmac <= (m == 0) ? 48'($urandom % 2) : 48'(m == 2);
    pkt_smac <= 48'($urandom % 2);
    pkt_etype <= 16'h0800 + 16'((m == 0) ? $urandom % 2 : 0);
    pkt_dip <= 32'($urandom % 4);
    pkt_sip <= 32'($urandom % 4);
    pkt_code <= 8'h06 + 8'($urandom % 2);
    pkt_dport <= 16'($urandom % 6);
    pkt_sport <= 16'($urandom % 6);
    pkt_seq <= {16'($urandom % 4), 16'($urandom % 4)};
    pkt_flags <= 6'($urandom % 2);
    #1 ex = expect_res();
    @(posedge clock);
    #1 ir = count_irq;
    if (m == 0) check(32'({res_valid, res_hit, res_prio, res_remark,
                           res_vlan_prio, res_map}), 32'(ex));
  endtask : send_pkt

  task automatic wait_irq(output int n);
    n = 0;
    while (count_irq !== 1'b1 && n < 60000) begin
      @(posedge clock);
      #1 n++;
    end
  endtask : wait_irq

  initial begin
    void'($urandom(32'h652F));
    {rstn, reg_wr, reg_rd, send, reg_addr, reg_wdata} = '0;
    {pkt_port, pkt_dmac, pkt_smac, pkt_etype, pkt_dip, pkt_sip} = '0;
    {pkt_code, pkt_is_tcp, pkt_is_udp, pkt_dport, pkt_sport} = '0;
    {pkt_seq, pkt_flags, port_acl_en} = '0;
    failures = 0;
    checks_done = 0;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    rd(ADDR_BYTE, d);
    check(32'(d), 32'h0);
    wr(ADDR_CTL_HI, 8'hF3);
    rd(ADDR_CTL_HI, d);
    check(32'(d), 32'hF3);
    rd(8'h70, d);
    check(32'(d), 32'h0);
    wr(ADDR_CTL_LO, 8'h1C);
    wr(ADDR_BYTE, 8'h55);
    rd(ADDR_BYTE, d);
    check(32'(d), 32'h0);
    // write then read on consecutive edges, no idle cycle between
    wr(ADDR_CTL_LO, 8'd27);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= ADDR_BYTE;
    reg_wdata <= 8'hA5;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 check(32'(reg_rdata), 32'hA5);
    for (int t = 0; t < 4; t++) begin
      for (int k = 0; k < ENTRIES; k++) begin
        tbl[k] = rand_entry(k);
        put(k);
      end
      wr(ADDR_CTL_HI, 8'(t));
      wr(ADDR_CTL_LO, 8'd25);
      rd(ADDR_BYTE, d);
      check(32'(d), 32'(tbl[t][200 +: 8]));
      @(posedge clock);
      port_acl_en <= 5'($urandom) | 5'h01;
      repeat (100) send_pkt(0, irq);
    end
    @(posedge clock);
    port_acl_en <= 5'h1F;
    tbl[0] = '0;
    tbl[0][F_POL] = 1'b1;
    tbl[0][1:0] = KIND_L2;
    tbl[0][F_ETYPE +: 16] = 16'h0800;
    tbl[0][F_COUNT +: CNT_W] = 11'd2;
    tbl[0][F_FWD + 3] = 1'b1;
    put(0);
    for (int i = 0; i < 6; i++) begin
      send_pkt(UP_MODE[i], irq);
      check(32'(irq), 32'(UP_IRQ[i]));
    end
    tbl[0][F_COUNT +: CNT_W] = 11'd3;
    tbl[0][F_FWD + 3] = 1'b0;
    put(0);
    send_pkt(1, irq);
    wait_irq(c);
    check(32'(c >= 101 && c <= 150), 32'h1);
    tbl[0][F_COUNT +: CNT_W] = 11'd1;
    tbl[0][F_FWD + 4] = 1'b1;
    put(0);
    send_pkt(1, irq);
    wait_irq(c);
    check(32'(c >= 60 && c <= 50010), 32'h1);
    stop_test();
  end

  initial begin
    repeat (80000) @(posedge clock);
    failures++;
    stop_test();
  end
endmodule : tb_acl_rule_filter_engine
`default_nettype wire
